// ### src/fsp_pkg.sv
// package: register map, flash command codes, timing and pin carriers for the flash host controller
package fsp_pkg;
  // own register map, byte addresses on the AHB-Lite bus
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // field positions
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_OP_LSB   = 8;
  localparam int ST_BUSY      = 0;
  localparam int ST_READY     = 1;
  localparam int ST_FAIL      = 2;
  localparam int ST_REFUSED   = 3;
  localparam int ST_IDENT     = 4;
  localparam int ST_SUSP      = 5;
  localparam int ST_LOCKOUT   = 6;
  // status bit positions of the flash data word
  localparam int POLL_BIT          = 7;
  localparam int TOGGLE_BIT        = 6;
  localparam int FAIL_BIT          = 5;
  localparam int LOCK_STATE_BIT    = 1;
  // flash command cycles
  localparam logic [18:0] UNLOCK_A1 = 19'h00555;
  localparam logic [18:0] UNLOCK_A2 = 19'h00AAA;
  localparam logic [18:0] CFI_ADDR  = 19'h00055;
  localparam logic [18:0] BLOCKB_LOCK_ADDR = 19'h00080;
  localparam logic [7:0]  UNLOCK_D1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_D2 = 8'h55;
  localparam logic [7:0]  OP_SUSPEND = 8'hB0;
  localparam logic [7:0]  OP_RESUME  = 8'h30;
  localparam logic [7:0]  OP_ID_EXIT = 8'hF0;
  localparam logic [7:0]  OP_ID_ENTRY = 8'h90;
  localparam logic [7:0]  OP_CFI     = 8'h98;
  localparam logic [7:0]  OP_PROGRAM = 8'hA0;
  localparam logic [15:0] FAIL_MASK_LOCK = 16'hFFFD;
  localparam int          SECTOR_LSB = 15;
  // timing
  localparam int CLK_MHZ     = 200;
  localparam int T_RD_NS     = 90;
  localparam int T_WR_NS     = 50;
  localparam int T_SUSP_US   = 20;
  localparam int T_POWERON_MS = 10;
  localparam int RD_CYC      = (T_RD_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC      = (T_WR_NS * CLK_MHZ + 999) / 1000;
  localparam int SUSP_CYC    = T_SUSP_US * CLK_MHZ;
  localparam int POWERON_CYC = T_POWERON_MS * 1000 * CLK_MHZ;
  localparam int SYNC_CYC    = 3;

  // command kinds carried in the CMD register
  typedef enum logic [2:0] {
    KIND_READ     = 3'b000,
    KIND_WRITE    = 3'b001,
    KIND_PREFIX   = 3'b010,
    KIND_PRE_WR   = 3'b011,
    KIND_PRE_RD   = 3'b100,
    KIND_LOCK_B   = 3'b101,
    KIND_POLL     = 3'b110,
    KIND_RSVD     = 3'b111
  } fsp_kind_t;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [18:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe_n;
  } fsp_pins_out_t;

  typedef struct packed {
    logic [15:0] dq_i;
    logic        ready_i;
  } fsp_pins_in_t;
endpackage : fsp_pkg

// ### src/fsp_host.sv
// flash host controller: AHB-Lite register slave driving a parallel NOR flash command bus
`timescale 1ns/1ps
module fsp_host #(
  parameter int POWERON_CYCLES = fsp_pkg::POWERON_CYC
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  output fsp_pkg::fsp_pins_out_t      pins_o,
  input  wire fsp_pkg::fsp_pins_in_t  pins_i
);
  initial
  begin
    if (POWERON_CYCLES < 1 || POWERON_CYCLES > 33554431)
      $error("POWERON_CYCLES out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b010,
    ST_RECOV  = 3'b011,
    ST_WAIT   = 3'b100
  } fsp_state_t;

  // three-stage pin synchroniser, stage one read only by stage two
  logic [16:0] sync1;
  logic [16:0] sync2;
  logic [16:0] sync3;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1 <= 17'h1FFFF;
      sync2 <= 17'h1FFFF;
      sync3 <= 17'h1FFFF;
    end
    else
    begin
      sync1 <= {pins_i.dq_i, pins_i.ready_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  logic sync_agree;
  assign sync_agree = (sync2 == sync3);

  // bus slave and register state
  logic        ap_wr;
  logic        ap_rd;
  logic [7:0]  ap_addr;
  logic [15:0] cmd;
  logic [18:0] fl_addr;
  logic [15:0] fl_wdata;
  logic [15:0] rdata;
  logic        fail;
  logic        refused;
  logic        ident;
  logic        susp;
  logic        ready_lvl;
  logic        next_ap_wr;
  logic        next_ap_rd;
  logic [7:0]  next_ap_addr;
  logic [15:0] next_cmd;
  logic [18:0] next_fl_addr;
  logic [15:0] next_fl_wdata;
  logic [31:0] next_hrdata;

  // engine state
  fsp_state_t  state;
  fsp_state_t  next_state;
  logic [1:0]  step;
  logic [1:0]  next_step;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic [24:0] lockout;
  logic [24:0] next_lockout;
  logic        have_first;
  logic        next_have_first;
  logic        fail_seen;
  logic        next_fail_seen;
  logic [15:0] first_rd;
  logic [15:0] next_first_rd;
  logic [15:0] next_rdata;
  logic        next_fail;
  logic        next_refused;
  logic        next_ident;
  logic        next_susp;
  logic [3:0]  prog_sector;
  logic [3:0]  next_prog_sector;
  fsp_pkg::fsp_pins_out_t next_pins;

  logic        start;
  logic        cmd_write;
  fsp_pkg::fsp_kind_t kind;
  logic [7:0]  op;
  logic        step_rd;
  logic [18:0] step_addr;
  logic [15:0] step_data;
  logic        last_step;
  logic        reject;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign kind      = fsp_pkg::fsp_kind_t'(cmd[fsp_pkg::CMD_KIND_LSB +: 3]);
  assign op        = cmd[fsp_pkg::CMD_OP_LSB +: 8];
  assign cmd_write = ap_wr && (ap_addr == fsp_pkg::REG_CMD);
  assign last_step = (step == 2'd3) || (kind == fsp_pkg::KIND_PREFIX && step == 2'd2);

  // acceptance check for a new command written while idle
  always_comb
  begin
    fsp_pkg::fsp_kind_t nk;
    logic [7:0]         nop;
    nk     = fsp_pkg::fsp_kind_t'(hwdata[fsp_pkg::CMD_KIND_LSB +: 3]);
    nop    = hwdata[fsp_pkg::CMD_OP_LSB +: 8];
    reject = 1'b0;
    if (state != ST_IDLE || nk == fsp_pkg::KIND_RSVD)
      reject = 1'b1;
    else if (lockout != 25'h0 && nk != fsp_pkg::KIND_READ && nk != fsp_pkg::KIND_POLL)
      reject = 1'b1;
    else if (ident && !(nk == fsp_pkg::KIND_READ || (nk == fsp_pkg::KIND_WRITE
             && (fl_wdata[7:0] == fsp_pkg::OP_ID_EXIT || fl_wdata[7:0] == fsp_pkg::OP_CFI))
             || (nk == fsp_pkg::KIND_PREFIX && nop == fsp_pkg::OP_ID_EXIT)))
      reject = 1'b1;
    else if (susp && (nk == fsp_pkg::KIND_READ || nk == fsp_pkg::KIND_POLL)
             && fl_addr[18:fsp_pkg::SECTOR_LSB] == prog_sector)
      reject = 1'b1;
    start = cmd_write && !reject;
  end

  // per-step address, data and direction of the command sequence
  always_comb
  begin
    step_rd   = 1'b0;
    step_addr = fsp_pkg::UNLOCK_A1;
    step_data = {8'h00, fsp_pkg::UNLOCK_D1};
    unique case (step)
      2'd0: step_data = {8'h00, fsp_pkg::UNLOCK_D1};
      2'd1:
      begin
        step_addr = fsp_pkg::UNLOCK_A2;
        step_data = {8'h00, fsp_pkg::UNLOCK_D2};
      end
      2'd2: step_data = {8'h00, op};
      2'd3:
      begin
        step_addr = fl_addr;
        step_data = fl_wdata;
        step_rd   = (kind == fsp_pkg::KIND_READ) || (kind == fsp_pkg::KIND_PRE_RD) ||
                    (kind == fsp_pkg::KIND_POLL);
        if (kind == fsp_pkg::KIND_LOCK_B)
        begin
          step_addr = fsp_pkg::BLOCKB_LOCK_ADDR;
          step_data = fl_wdata & fsp_pkg::FAIL_MASK_LOCK;
        end
        else if (kind == fsp_pkg::KIND_WRITE && fl_wdata[7:0] == fsp_pkg::OP_SUSPEND)
          step_addr = 19'h00000;
      end
      default: step_data = 16'h0000;
    endcase
  end

  // engine next state
  always_comb
  begin
    next_state       = state;
    next_step        = step;
    next_cnt         = cnt;
    next_lockout     = (lockout != 25'h0) ? lockout - 25'd1 : lockout;
    next_have_first  = have_first;
    next_fail_seen   = fail_seen;
    next_first_rd    = first_rd;
    next_rdata       = rdata;
    next_ident       = ident;
    next_susp        = susp;
    next_prog_sector = prog_sector;
    next_fail        = fail;
    next_refused     = refused;
    next_pins        = pins_o;
    if (ap_wr && ap_addr == fsp_pkg::REG_STATUS)
    begin
      if (hwdata[fsp_pkg::ST_FAIL])
        next_fail = 1'b0;
      if (hwdata[fsp_pkg::ST_REFUSED])
        next_refused = 1'b0;
    end
    if (cmd_write && reject)
      next_refused = 1'b1;
    unique case (state)
      ST_IDLE:
      if (start)
      begin
        next_state      = ST_SETUP;
        next_have_first = 1'b0;
        next_fail_seen  = 1'b0;
        next_step       = (hwdata[2:0] == 3'd0 || hwdata[2:0] == 3'd1 || hwdata[2:0] == 3'd6) ? 2'd3 : 2'd0;
      end
      ST_SETUP:
      begin
        // address, data and strobe launch together; output gate stays high on writes
        next_pins.ce_n    = 1'b0;
        next_pins.addr    = step_addr;
        next_pins.dq_o    = step_data;
        next_pins.dq_oe_n = step_rd;
        next_pins.oe_n    = !step_rd;
        next_pins.we_n    = step_rd;
        next_cnt          = step_rd ? 12'(fsp_pkg::RD_CYC + fsp_pkg::SYNC_CYC) : 12'(fsp_pkg::WR_CYC);
        next_state        = ST_STROBE;
      end
      ST_STROBE:
      if (cnt > 12'd1)
        next_cnt = cnt - 12'd1;
      else if (!step_rd || sync_agree)
      begin
        next_pins.ce_n = 1'b1;
        next_pins.oe_n = 1'b1;
        next_pins.we_n = 1'b1;
        next_state     = ST_RECOV;
        if (step_rd)
        begin
          next_rdata = sync3[16:1];
          if (kind == fsp_pkg::KIND_POLL && !have_first)
            next_first_rd = sync3[16:1];
        end
      end
      ST_RECOV:
      begin
        next_pins.dq_oe_n = 1'b1;
        next_cnt          = 12'd1;
        next_state        = ST_WAIT;
        if (!last_step)
          next_state = ST_WAIT;
        else if (kind == fsp_pkg::KIND_POLL && !have_first)
        begin
          next_have_first = 1'b1; // first word held, take the second
          next_state      = ST_SETUP;
        end
        else if (kind == fsp_pkg::KIND_POLL &&
                 first_rd[fsp_pkg::TOGGLE_BIT] != rdata[fsp_pkg::TOGGLE_BIT])
        begin
          // toggle still moving: a set fail bit earns one more pair of reads
          next_have_first = 1'b0;
          next_state      = ST_SETUP;
          if (rdata[fsp_pkg::FAIL_BIT])
          begin
            next_fail_seen = 1'b1;
            if (fail_seen)
            begin
              next_fail  = 1'b1;
              next_state = ST_WAIT;
            end
          end
        end
        else
        begin
          if (kind == fsp_pkg::KIND_WRITE)
          begin
            if (fl_wdata[7:0] == fsp_pkg::OP_SUSPEND)
            begin
              next_susp = 1'b1;
              next_cnt  = 12'(fsp_pkg::SUSP_CYC);
            end
            if (fl_wdata[7:0] == fsp_pkg::OP_RESUME)
              next_susp = 1'b0;
            if (fl_wdata[7:0] == fsp_pkg::OP_CFI && fl_addr == fsp_pkg::CFI_ADDR)
              next_ident = 1'b1;
            if (fl_wdata[7:0] == fsp_pkg::OP_ID_EXIT)
              next_ident = 1'b0;
          end
          if (kind == fsp_pkg::KIND_PREFIX || kind == fsp_pkg::KIND_PRE_RD)
            next_ident = (op == fsp_pkg::OP_ID_ENTRY);
          if (kind == fsp_pkg::KIND_PRE_WR && op == fsp_pkg::OP_PROGRAM)
            next_prog_sector = fl_addr[18:fsp_pkg::SECTOR_LSB];
        end
      end
      ST_WAIT:
      if (cnt > 12'd1)
        next_cnt = cnt - 12'd1;
      else if (!last_step)
      begin
        // step advances only after the gap, so the final cycle is never skipped
        next_step  = step + 2'd1;
        next_state = ST_SETUP;
      end
      else
        next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // engine registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state       <= ST_IDLE;
      step        <= 2'd0;
      cnt         <= 12'h000;
      lockout     <= 25'(POWERON_CYCLES);
      have_first  <= 1'b0;
      fail_seen   <= 1'b0;
      first_rd    <= 16'h0000;
      rdata       <= 16'h0000;
      fail        <= 1'b0;
      refused     <= 1'b0;
      ident       <= 1'b0;
      susp        <= 1'b0;
      prog_sector <= 4'h0;
      pins_o      <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 19'h00000, dq_o: 16'h0000, dq_oe_n: 1'b1};
    end
    else
    begin
      state       <= next_state;
      step        <= next_step;
      cnt         <= next_cnt;
      lockout     <= next_lockout;
      have_first  <= next_have_first;
      fail_seen   <= next_fail_seen;
      first_rd    <= next_first_rd;
      rdata       <= next_rdata;
      fail        <= next_fail;
      refused     <= next_refused;
      ident       <= next_ident;
      susp        <= next_susp;
      prog_sector <= next_prog_sector;
      pins_o      <= next_pins;
    end
  end

  // AHB-Lite slave: zero wait, read data prepared in the address phase
  always_comb
  begin
    logic ap_ok;
    ap_ok         = hsel && hready && htrans[1];
    next_ap_wr    = ap_ok && hwrite;
    next_ap_rd    = ap_ok && !hwrite;
    next_ap_addr  = haddr[7:0];
    next_cmd      = (cmd_write && !reject) ? hwdata[15:0] : cmd;
    next_fl_addr  = (ap_wr && ap_addr == fsp_pkg::REG_ADDR && state == ST_IDLE) ? hwdata[18:0] : fl_addr;
    next_fl_wdata = (ap_wr && ap_addr == fsp_pkg::REG_WDATA && state == ST_IDLE) ? hwdata[15:0] : fl_wdata;
    next_hrdata   = 32'h00000000;
    if (ap_ok && !hwrite)
    begin
      unique case (haddr[7:0])
        fsp_pkg::REG_CMD:    next_hrdata = {16'h0000, cmd};
        fsp_pkg::REG_ADDR:   next_hrdata = {13'h0000, fl_addr};
        fsp_pkg::REG_WDATA:  next_hrdata = {16'h0000, fl_wdata};
        fsp_pkg::REG_RDATA:  next_hrdata = {16'h0000, rdata};
        fsp_pkg::REG_STATUS: next_hrdata = {25'h0000000, lockout != 25'h0, susp, ident, refused,
                                            fail, ready_lvl, state != ST_IDLE};
        default:             next_hrdata = 32'h00000000;
      endcase
    end
  end

  // bus registers; the ready level only follows the synchroniser once stages agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_wr     <= 1'b0;
      ap_rd     <= 1'b0;
      ap_addr   <= 8'h00;
      cmd       <= 16'h0000;
      fl_addr   <= 19'h00000;
      fl_wdata  <= 16'h0000;
      hrdata    <= 32'h00000000;
      ready_lvl <= 1'b1;
    end
    else
    begin
      ap_wr     <= next_ap_wr;
      ap_rd     <= next_ap_rd;
      ap_addr   <= next_ap_addr;
      cmd       <= next_cmd;
      fl_addr   <= next_fl_addr;
      fl_wdata  <= next_fl_wdata;
      hrdata    <= next_hrdata;
      ready_lvl <= (sync2[0] == sync3[0]) ? sync3[0] : ready_lvl;
    end
  end
endmodule : fsp_host

// ### verif/fsp_host_asserts.sv
// checker: bus answer and flash pin timing of the host controller
`timescale 1ns/1ps
module fsp_host_asserts #(
  parameter int POWERON_CYCLES = fsp_pkg::POWERON_CYC
) (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire fsp_pkg::fsp_pins_out_t pins_o
);
  localparam int GAP = fsp_pkg::SUSP_CYC;
  logic [31:0] up_cnt;
  logic [31:0] gap_cnt;
  logic        we_q;
  logic [31:0] next_up;
  logic [31:0] next_gap;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // saturating age counter and post-suspend quiet window
  always_comb
  begin
    next_up  = (up_cnt < POWERON_CYCLES) ? up_cnt + 32'h1 : up_cnt;
    next_gap = (gap_cnt != 32'h0) ? gap_cnt - 32'h1 : 32'h0;
    if (pins_o.we_n && !we_q && pins_o.dq_o[7:0] == fsp_pkg::OP_SUSPEND)
      next_gap = GAP;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      up_cnt  <= 32'h0;
      gap_cnt <= 32'h0;
      we_q    <= 1'h1;
    end
    else
    begin
      up_cnt  <= next_up;
      gap_cnt <= next_gap;
      we_q    <= pins_o.we_n;
    end
  end
  // strobe shapes: ten-cycle write pulse, read held at least 21 cycles
  sequence s_we;
    (!pins_o.we_n && !pins_o.ce_n)[*8] ##1 (!pins_o.we_n)[*2] ##1 (pins_o.we_n && pins_o.ce_n);
  endsequence
  sequence s_rd;
    (!pins_o.oe_n && pins_o.dq_oe_n)[*8] ##1 (!pins_o.oe_n)[*8] ##1 (!pins_o.oe_n)[*5];
  endsequence
  property p_bus_okay; hreadyout && !hresp; endproperty
  property p_no_prog_oe; !pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n; endproperty
  property p_we_pulse; $fell(pins_o.we_n) |-> s_we; endproperty
  property p_setup; $fell(pins_o.ce_n) |-> pins_o.we_n != pins_o.oe_n; endproperty
  property p_rd_strobe; $fell(pins_o.oe_n) |-> s_rd; endproperty
  property p_addr_hold; !pins_o.ce_n |=> $stable(pins_o.addr); endproperty
  property p_dq_drive; !pins_o.we_n |-> !pins_o.dq_oe_n && ($fell(pins_o.we_n) || $stable(pins_o.dq_o)); endproperty
  property p_susp_addr; !pins_o.we_n && pins_o.dq_o[7:0] == fsp_pkg::OP_SUSPEND |-> pins_o.addr == 19'h0; endproperty
  property p_lock_bit; !pins_o.we_n && pins_o.addr == fsp_pkg::BLOCKB_LOCK_ADDR |-> !pins_o.dq_o[1]; endproperty
  property p_lockout; up_cnt < POWERON_CYCLES |-> pins_o.we_n; endproperty
  property p_susp_gap; gap_cnt != 32'h0 |-> pins_o.ce_n; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
  a_no_prog_oe: assert property (p_no_prog_oe) else $error("write strobe with bad gating");
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse shape wrong");
  a_setup: assert property (p_setup) else $error("cycle opened without exactly one strobe");
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe too short");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved inside a cycle");
  a_dq_drive: assert property (p_dq_drive) else $error("data not driven steady in write");
  a_susp_addr: assert property (p_susp_addr) else $error("suspend address not zero");
  a_lock_bit: assert property (p_lock_bit) else $error("lock cycle with bit one set");
  a_lockout: assert property (p_lockout) else $error("write during power-on lockout");
  a_susp_gap: assert property (p_susp_gap) else $error("cycle inside suspend wait");
endmodule : fsp_host_asserts

// ### verif/fsp_flash_model.sv
// behavioural flash: command decode, program timer, protection register, status bits
`timescale 1ns/1ps
module fsp_flash_model #(
  parameter int          BUSY_CYC = 300,
  parameter logic [15:0] FACTORY  = 16'hA5A0 // arbitrary factory pattern
) (
  input  wire logic                   clk,
  input  wire fsp_pkg::fsp_pins_out_t p,
  output fsp_pkg::fsp_pins_in_t       q
);
  logic [15:0] mem [logic [18:0]];
  logic [15:0] prot [8];
  logic [15:0] pd, last;
  logic [7:0]  d, op;
  logic [1:0]  seq;
  logic        lock, ident, cfi, susp, fail, tog, ce_q;
  int          busy;
  initial
  begin
    for (int i = 0; i < 8; i++) prot[i] = (i < 4) ? FACTORY + 16'(i) : 16'hFFFF;
    {seq, lock, ident, cfi, susp, fail, tog, busy, last, pd, op} = '0;
  end
  // strobes rise together, so chip select is judged one clock back
  always @(posedge clk) ce_q <= p.ce_n;
  // commands latch on the rising write strobe; gated strobes are ignored
  always @(posedge p.we_n)
  begin
    d = p.dq_o[7:0];
    if (!ce_q && p.oe_n)
    begin
      if (busy > 0 && !susp) susp = (d == fsp_pkg::OP_SUSPEND);
      else if (susp && d == fsp_pkg::OP_RESUME) susp = 0;
      else if (seq == 2'h3)
      begin
        seq = 0;
        if (op == fsp_pkg::OP_PROGRAM && p.addr[18:15] == 4'hF) fail = 1;
        else if (op == fsp_pkg::OP_PROGRAM)
        begin
          mem[p.addr] = p.dq_o;
          pd = p.dq_o;
          busy = BUSY_CYC;
        end
        else if (p.addr == fsp_pkg::BLOCKB_LOCK_ADDR) lock |= !p.dq_o[1];
        else if (!lock && p.addr >= 19'h85 && p.addr <= 19'h88) prot[p.addr[2:0] - 3'h1] = p.dq_o;
      end
      else if (d == fsp_pkg::OP_ID_EXIT) {seq, ident, cfi, fail} = '0;
      else if (d == fsp_pkg::OP_CFI && p.addr[7:0] == 8'h55) cfi = 1;
      else if (seq == 2'h2 && p.addr == fsp_pkg::UNLOCK_A1)
      begin
        op = d;
        ident |= (d == fsp_pkg::OP_ID_ENTRY);
        seq = (d == fsp_pkg::OP_ID_ENTRY) ? 2'h0 : 2'h3;
      end
      else if (p.addr == fsp_pkg::UNLOCK_A1 && d == fsp_pkg::UNLOCK_D1) seq = 1;
      else seq = (seq == 2'h1 && p.addr == fsp_pkg::UNLOCK_A2 && d == fsp_pkg::UNLOCK_D2) ? 2'h2 : 2'h0;
    end
  end
  // read word chosen as the output gate falls; status words while busy or failed
  always @(negedge p.oe_n)
  begin
    if ((busy > 0 && !susp) || fail)
    begin
      tog = ~tog;
      last = {8'h00, ~pd[7], tog, fail, 5'h00};
    end
    else if (cfi) last = 16'h0051;
    else if (ident && p.addr == fsp_pkg::BLOCKB_LOCK_ADDR) last = {14'h3FFF, ~lock, 1'h1};
    else if (ident && p.addr >= 19'h81 && p.addr <= 19'h88) last = prot[p.addr[2:0] - 3'h1];
    else last = mem.exists(p.addr) ? mem[p.addr] : 16'hFFFF;
  end
  // released data bus shows the inverse, so a stale word cannot pass
  assign q.dq_i    = (!p.ce_n && !p.oe_n) ? last : ~last;
  assign q.ready_i = !(busy > 0 && !susp);
  always @(posedge clk) if (busy > 0 && !susp) busy <= busy - 1;
endmodule : fsp_flash_model

// ### verif/fsp_host_test.sv
// testbench: host controller over AHB-Lite against the behavioural flash
`timescale 1ns/1ps
module fsp_host_test;
  localparam int PON = 50;
  logic                   hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]            haddr, hwdata, hrdata, st, r;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  fsp_pkg::fsp_pins_out_t po;
  fsp_pkg::fsp_pins_in_t  pi;
  int                     fail_count = 0;
  int                     comparisons = 0;
  assign hready = hreadyout;
  fsp_host #(.POWERON_CYCLES(PON)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pins_o(po), .pins_i(pi));
  fsp_flash_model u_flash (.clk(hclk), .p(po), .q(pi));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one single transfer: address phase, then data phase, both held until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'h1, a, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'h0, a, 32'h0, d);
  endtask : rd
  // issue a command and wait, bounded, until busy drops; last status left in st
  task automatic cmd(input fsp_pkg::fsp_kind_t k, input logic [18:0] a, input logic [15:0] d,
                     input logic [7:0] op = 8'h00);
    int n;
    wr(fsp_pkg::REG_ADDR, {13'h0, a});
    wr(fsp_pkg::REG_WDATA, {16'h0, d});
    wr(fsp_pkg::REG_CMD, {16'h0, op, 5'h0, k});
    n = 0;
    do
    begin
      rd(fsp_pkg::REG_STATUS, st);
      n++;
    end
    while (st[fsp_pkg::ST_BUSY] !== 1'h0 && n < 3000);
    check(n < 3000, 1'h1);
  endtask : cmd
  task automatic t_lockout;
    cmd(fsp_pkg::KIND_WRITE, 19'h0, {8'h00, fsp_pkg::OP_ID_EXIT});
    check(st[fsp_pkg::ST_REFUSED], 1'h1);
    check(st[fsp_pkg::ST_LOCKOUT], 1'h1);
    repeat (PON) @(posedge hclk);
    wr(fsp_pkg::REG_STATUS, 32'h8);
    cmd(fsp_pkg::KIND_RSVD, 19'h0, 16'h0);
    check(st[fsp_pkg::ST_REFUSED], 1'h1);
    wr(fsp_pkg::REG_STATUS, 32'h8);
    rd(8'h20, r);
    check(r, 32'h0);
    rd(fsp_pkg::REG_STATUS, r);
    check(r[6:2], 5'h00);
  endtask : t_lockout
  task automatic t_prog;
    cmd(fsp_pkg::KIND_PRE_WR, 19'h01234, 16'h5A3C, fsp_pkg::OP_PROGRAM);
    rd(fsp_pkg::REG_STATUS, st);
    check(st[fsp_pkg::ST_READY], 1'h0);
    cmd(fsp_pkg::KIND_POLL, 19'h01234, 16'h0);
    check(st[fsp_pkg::ST_FAIL], 1'h0);
    check(st[fsp_pkg::ST_READY], 1'h1);
    rd(fsp_pkg::REG_RDATA, r);
    check(r[15:0], 16'h5A3C);
  endtask : t_prog
  task automatic t_susp;
    cmd(fsp_pkg::KIND_PRE_WR, 19'h11000, 16'h00C3, fsp_pkg::OP_PROGRAM);
    cmd(fsp_pkg::KIND_WRITE, 19'h7FFFF, {8'h00, fsp_pkg::OP_SUSPEND});
    check(st[fsp_pkg::ST_SUSP], 1'h1);
    check(st[fsp_pkg::ST_READY], 1'h1);
    cmd(fsp_pkg::KIND_READ, 19'h11004, 16'h0);
    check(st[fsp_pkg::ST_REFUSED], 1'h1);
    wr(fsp_pkg::REG_STATUS, 32'h8);
    cmd(fsp_pkg::KIND_READ, 19'h01234, 16'h0);
    rd(fsp_pkg::REG_RDATA, r);
    check(r[15:0], 16'h5A3C);
    cmd(fsp_pkg::KIND_WRITE, 19'h0, {8'h00, fsp_pkg::OP_RESUME});
    check(st[fsp_pkg::ST_SUSP], 1'h0);
    rd(fsp_pkg::REG_STATUS, st);
    check(st[fsp_pkg::ST_READY], 1'h0);
    cmd(fsp_pkg::KIND_POLL, 19'h11000, 16'h0);
    rd(fsp_pkg::REG_RDATA, r);
    check(r[15:0], 16'h00C3);
  endtask : t_susp
  task automatic t_prot;
    cmd(fsp_pkg::KIND_PRE_WR, 19'h00085, 16'h1234, 8'hC0);
    cmd(fsp_pkg::KIND_LOCK_B, 19'h0, 16'hFFFF, 8'hC0);
    cmd(fsp_pkg::KIND_PRE_WR, 19'h00085, 16'h0000, 8'hC0);
    cmd(fsp_pkg::KIND_PRE_WR, 19'h00081, 16'h0000, 8'hC0);
    cmd(fsp_pkg::KIND_PRE_RD, fsp_pkg::BLOCKB_LOCK_ADDR, 16'h0, fsp_pkg::OP_ID_ENTRY);
    check(st[fsp_pkg::ST_IDENT], 1'h1);
    rd(fsp_pkg::REG_RDATA, r);
    check(r[fsp_pkg::LOCK_STATE_BIT], 1'h0);
    cmd(fsp_pkg::KIND_READ, 19'h00085, 16'h0);
    rd(fsp_pkg::REG_RDATA, r);
    check(r[15:0], 16'h1234);
    cmd(fsp_pkg::KIND_READ, 19'h00081, 16'h0);
    rd(fsp_pkg::REG_RDATA, r);
    check(r[15:0], 16'hA5A0);
    cmd(fsp_pkg::KIND_PRE_WR, 19'h00085, 16'h0, 8'hC0);
    check(st[fsp_pkg::ST_REFUSED], 1'h1);
    wr(fsp_pkg::REG_STATUS, 32'h8);
    cmd(fsp_pkg::KIND_WRITE, 19'h0, {8'h00, fsp_pkg::OP_ID_EXIT});
    check(st[fsp_pkg::ST_IDENT], 1'h0);
  endtask : t_prot
  // query entry from read mode and from ident mode, both left by the exit write
  task automatic t_cfi;
    for (int m = 0; m < 2; m++)
    begin
      if (m == 1) cmd(fsp_pkg::KIND_PREFIX, 19'h0, 16'h0, fsp_pkg::OP_ID_ENTRY);
      cmd(fsp_pkg::KIND_WRITE, fsp_pkg::CFI_ADDR, {8'h00, fsp_pkg::OP_CFI});
      check(st[4:3], 2'h2);
      cmd(fsp_pkg::KIND_READ, 19'h00010, 16'h0);
      rd(fsp_pkg::REG_RDATA, r);
      check(r[15:0], 16'h0051);
      cmd(fsp_pkg::KIND_WRITE, 19'h0, {8'h00, fsp_pkg::OP_ID_EXIT});
      check(st[fsp_pkg::ST_IDENT], 1'h0);
    end
  endtask : t_cfi
  task automatic t_fail;
    cmd(fsp_pkg::KIND_PRE_WR, 19'h78000, 16'h0001, fsp_pkg::OP_PROGRAM);
    cmd(fsp_pkg::KIND_POLL, 19'h78000, 16'h0);
    check(st[fsp_pkg::ST_FAIL], 1'h1);
    rd(fsp_pkg::REG_RDATA, r);
    check(r[fsp_pkg::FAIL_BIT], 1'h1);
    cmd(fsp_pkg::KIND_WRITE, 19'h0, {8'h00, fsp_pkg::OP_ID_EXIT});
    wr(fsp_pkg::REG_STATUS, 32'h4);
    cmd(fsp_pkg::KIND_READ, 19'h78000, 16'h0);
    check(st[fsp_pkg::ST_FAIL], 1'h0);
    rd(fsp_pkg::REG_RDATA, r);
    check(r[15:0], 16'hFFFF);
  endtask : t_fail
  task automatic tally_and_finish;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  // hang guard, several times the expected run length
  initial
  begin
    #400000;
    fail_count++;
    tally_and_finish;
  end
  initial
  begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    t_lockout;
    t_prog;
    t_susp;
    t_prot;
    t_cfi;
    t_fail;
    tally_and_finish;
  end
endmodule : fsp_host_test
bind fsp_host fsp_host_asserts #(.POWERON_CYCLES(POWERON_CYCLES)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .pins_o(pins_o));
